/* File: core/ssr_top.sv */
// reset supervisor core with write gating and page buffer
//
// Overview of operation
// - supply low asserts both reset outputs
// - hold reset full timeout after supply returns
// - manual push low resets, then timeout
// - manual push input is debounced
// - floating manual push reads inactive high
// - external low on reset line causes reset
// - reset outputs are one-sided drivers: the low one is open drain, the high one only sources
// - write protect high rejects all writes
// - write protect low allows non-empty page writes once supply is good
// - supply low blocks writes, including power up
// - write path buffers one 16 byte page
`timescale 1ns/1ps
module ssr_top #(
  parameter int unsigned TIMEOUT_CYC = ssr_pkg::TIMEOUT_CYC,
  parameter int unsigned PAGE_BYTES  = ssr_pkg::PAGE_BYTES
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // supply comparator, already synchronous
  input  wire logic                      supply_low,
  // manual push input, pull-up applied by the pad
  input  wire logic                      manual_push_input,
  // active low reset line, open drain
  input  wire logic                      rst_line_in,
  output logic                           rst_line_oe_ff,
  output logic                           rst_line_out_ff,
  // active high reset output, drives only high
  output logic                           rst_hi_oe_ff,
  output logic                           rst_hi_out_ff,
  // write protect, pull-down applied by the pad
  input  wire logic                      write_protect,
  // memory write request side
  input  wire logic                      wr_byte_valid,
  input  wire logic [7:0]                wr_byte,
  input  wire logic                      wr_start,
  input  wire logic [ssr_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic                      wr_commit,
  // programming side
  output logic                           prog_valid_ff,
  output logic [ssr_pkg::ADDR_W-1:0]     prog_addr_ff,
  output logic [4:0]                     prog_count_ff,
  output logic                           wr_reject_ff,
  output logic                           wr_enable_ff,
  output logic                           in_reset_ff
);
  typedef enum logic [2:0] {
    SSR_ASSERT  = 3'b001,
    SSR_TIMEOUT = 3'b010,
    SSR_IDLE    = 3'b100
  } ssr_state_e;

  ssr_state_e  state_ff;
  logic [31:0] tmo_ff;
  logic        push_clean;
  logic        line_low;
  logic        cause;
  logic        int_cause;
  ssr_state_e  nxt_state;
  logic        supply_seen_ff;
  logic [7:0]  page_mem [PAGE_BYTES];
  logic [3:0]  page_idx_ff;
  logic [4:0]  page_cnt_ff;

  function automatic logic write_ok(input logic low, input logic seen, input logic wp);
    write_ok = !low && seen && !wp;
  endfunction

  ssr_debounce u_deb (
    .mclk    (mclk),
    .rst     (rst),
    .din     (manual_push_input),
    .dout_ff (push_clean)
  );

  // causes from inside the block; these always make us pull the wire ourselves
  assign int_cause = supply_low || !push_clean;
  // the wire shows our own pull while we drive, so only trust it with the driver off;
  // this keeps the line from latching itself in reset
  assign line_low  = !rst_line_in && !rst_line_oe_ff;
  assign cause     = int_cause || line_low;

  // limitation: an outside hold that overlaps an inside cause is not seen
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SSR_ASSERT:
      begin
        if (!cause)
          nxt_state = SSR_TIMEOUT;
      end
      SSR_TIMEOUT:
      begin
        if (cause)
          nxt_state = SSR_ASSERT;
        else if (tmo_ff >= 32'(TIMEOUT_CYC - 1))
          nxt_state = SSR_IDLE;
      end
      SSR_IDLE:
      begin
        if (cause)
          nxt_state = SSR_ASSERT;
      end
      default:
      begin
        nxt_state = SSR_ASSERT;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_ff <= SSR_ASSERT;
    else
      state_ff <= nxt_state;
  end

  // timeout counted in clock cycles, restarted on every entry
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tmo_ff <= 32'h0000_0000;
    else if (state_ff == SSR_TIMEOUT && nxt_state == SSR_TIMEOUT)
      tmo_ff <= tmo_ff + 32'h0000_0001;
    else
      tmo_ff <= 32'h0000_0000;
  end

  // outputs: low side only sinks, high side only sources
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rst_line_oe_ff  <= 1'b1;
      rst_line_out_ff <= 1'b0;
      rst_hi_oe_ff    <= 1'b1;
      rst_hi_out_ff   <= 1'b1;
      in_reset_ff     <= 1'b1;
    end
    else
    begin
      // outside hold only: let go of the wire so its release stays visible,
      // costs a short high blip on the wire before the timeout pull starts
      rst_line_oe_ff  <= (nxt_state == SSR_TIMEOUT) ||
                         (nxt_state == SSR_ASSERT && int_cause);
      rst_line_out_ff <= 1'b0;
      rst_hi_oe_ff    <= (nxt_state != SSR_IDLE);
      rst_hi_out_ff   <= 1'b1;
      in_reset_ff     <= (nxt_state != SSR_IDLE);
    end
  end

  // supply must have reached threshold at least once since power up
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      supply_seen_ff <= 1'b0;
    else if (!supply_low)
      supply_seen_ff <= 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wr_enable_ff <= 1'b0;
    else
      wr_enable_ff <= write_ok(supply_low, supply_seen_ff, write_protect);
  end

  // page buffer; address wraps inside the page, later bytes overwrite
  always_ff @(posedge mclk)
  begin
    if (wr_byte_valid)
      page_mem[page_idx_ff] <= wr_byte;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      page_idx_ff   <= 4'h0;
      page_cnt_ff   <= 5'h00;
      prog_valid_ff <= 1'b0;
      prog_addr_ff  <= '0;
      prog_count_ff <= 5'h00;
      wr_reject_ff  <= 1'b0;
    end
    else
    begin
      prog_valid_ff <= 1'b0;
      wr_reject_ff  <= 1'b0;
      if (wr_start)
      begin
        page_idx_ff  <= wr_addr[3:0];
        page_cnt_ff  <= 5'h00;
        prog_addr_ff <= wr_addr;
      end
      else if (wr_byte_valid)
      begin
        page_idx_ff <= page_idx_ff + 4'h1;
        if (page_cnt_ff < 5'(PAGE_BYTES))
          page_cnt_ff <= page_cnt_ff + 5'h01;
      end
      else if (wr_commit)
      begin
        page_cnt_ff <= 5'h00;
        if (write_ok(supply_low, supply_seen_ff, write_protect) && page_cnt_ff != 5'h00)
        begin
          prog_valid_ff <= 1'b1;
          prog_count_ff <= page_cnt_ff;
        end
        else
          wr_reject_ff <= 1'b1;
      end
    end
  end

  // only byte 0 of the buffer is tapped, into unused_peek, which nothing reads
  logic [7:0] unused_peek;
  assign unused_peek = page_mem[4'h0];
endmodule

/* File: core/ssr_pkg.sv */
// constants for the supply supervisor with reset and write protect
package ssr_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned TIMEOUT_MS      = 200;
  localparam int unsigned TIMEOUT_CYC     = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned PUSH_GLITCH_NS  = 100;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // debounce must outlast the glitch window, round up
  localparam int unsigned DEB_CYC         =
    (PUSH_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned PAGE_BYTES      = 16;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned PAGE_IDX_W      = 4;
endpackage

/* File: core/ssr_debounce.sv */
// debounce filter for the manual push input
`timescale 1ns/1ps
module ssr_debounce #(
  parameter int unsigned STABLE_CYC = ssr_pkg::DEB_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // raw and filtered level
  input  wire logic din,
  output logic      dout_ff
);
  logic [7:0] cnt_ff;

  // output only follows after the input held steady long enough
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= 8'h00;
      dout_ff <= 1'b1;
    end
    else if (din == dout_ff)
    begin
      cnt_ff <= 8'h00;
    end
    else if (cnt_ff >= 8'(STABLE_CYC - 1))
    begin
      cnt_ff  <= 8'h00;
      dout_ff <= din;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule

/* File: verif/ssr_props.sv */
// assertion checker for the reset supervisor
`timescale 1ns/1ps
module ssr_props #(
  parameter int unsigned TIMEOUT_CYC = ssr_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input logic       mclk,
  input logic       rst,
  // causes
  input logic       supply_low,
  input logic       manual_push_input,
  input logic       rst_line_in,
  // reset drivers
  input logic       rst_line_oe_ff,
  input logic       rst_line_out_ff,
  input logic       rst_hi_oe_ff,
  input logic       rst_hi_out_ff,
  input logic       in_reset_ff,
  // write gating
  input logic       write_protect,
  input logic       wr_commit,
  input logic       prog_valid_ff,
  input logic       wr_reject_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [31:0] quiet_ff;
  // raw quiet run, only a lower bound since debounce lags
  always_ff @(posedge mclk or posedge rst)
    if (rst) quiet_ff <= 32'h0;
    else quiet_ff <= (supply_low || !manual_push_input) ? 32'h0 : quiet_ff + 32'h1;
  sequence s_push_low; !manual_push_input [*6]; endsequence
  property p_sup; supply_low |=> rst_line_oe_ff && rst_hi_oe_ff; endproperty
  // low side may let go while an outsider holds the wire, never the other way
  property p_pair; rst_hi_oe_ff == in_reset_ff && (rst_hi_oe_ff || !rst_line_oe_ff); endproperty
  property p_od; !rst_line_out_ff && rst_hi_out_ff; endproperty
  property p_hold; $fell(in_reset_ff) |-> quiet_ff >= TIMEOUT_CYC; endproperty
  property p_push; s_push_low |=> in_reset_ff; endproperty
  property p_glitch;
    $rose(in_reset_ff) |-> $past(supply_low) || !$past(rst_line_in) || !$past(manual_push_input, 3);
  endproperty
  property p_line; !rst_line_in && !rst_line_oe_ff |=> in_reset_ff && rst_hi_oe_ff; endproperty
  property p_wp; wr_commit && write_protect |=> !prog_valid_ff && wr_reject_ff; endproperty
  a_sup: assert property (p_sup) else $error("no reset on supply low");
  a_pair: assert property (p_pair) else $error("reset outputs differ");
  a_od: assert property (p_od) else $error("driver level wrong");
  a_hold: assert property (p_hold) else $error("reset released early");
  a_push: assert property (p_push) else $error("no reset on push");
  a_glitch: assert property (p_glitch) else $error("reset without cause");
  a_line: assert property (p_line) else $error("line low ignored");
  a_wp: assert property (p_wp) else $error("protected write taken");
endmodule
bind ssr_top ssr_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .mclk              (mclk),
  .rst               (rst),
  .supply_low        (supply_low),
  .manual_push_input (manual_push_input),
  .rst_line_in       (rst_line_in),
  .rst_line_oe_ff    (rst_line_oe_ff),
  .rst_line_out_ff   (rst_line_out_ff),
  .rst_hi_oe_ff      (rst_hi_oe_ff),
  .rst_hi_out_ff     (rst_hi_out_ff),
  .in_reset_ff       (in_reset_ff),
  .write_protect     (write_protect),
  .wr_commit         (wr_commit),
  .prog_valid_ff     (prog_valid_ff),
  .wr_reject_ff      (wr_reject_ff)
);

/* File: verif/ssr_mcu.sv */
// system controller model on the reset wire
`timescale 1ns/1ps
module ssr_mcu (
  // device pull and controller force
  input  wire logic rst_line_oe,
  input  wire logic force_low,
  // wire level, pull-up when nobody pulls
  output logic      rst_line
);
  assign rst_line = !(rst_line_oe || force_low);
endmodule

/* File: verif/ssr_top_tb_top.sv */
// testbench for the reset supervisor
`timescale 1ns/1ps
module ssr_top_tb_top;
  localparam int unsigned TO = 20;
  logic mclk = 0, rst = 1, sl = 1, push = 1, wp = 0, fl = 0, bv = 0, st = 0, cm = 0;
  logic line, loe, hoe, pv, rj, ir, we;
  logic [7:0] b = 8'h00, a = 8'h00, pa;
  logic [4:0] pc;
  int num_errors = 0, check_count = 0, n;
  ssr_top #(.TIMEOUT_CYC(TO)) dut (.mclk(mclk), .rst(rst), .supply_low(sl),
    .manual_push_input(push), .rst_line_in(line), .rst_line_oe_ff(loe),
    .rst_line_out_ff(), .rst_hi_oe_ff(hoe), .rst_hi_out_ff(), .write_protect(wp),
    .wr_byte_valid(bv), .wr_byte(b), .wr_start(st), .wr_addr(a), .wr_commit(cm),
    .prog_valid_ff(pv), .prog_addr_ff(pa), .prog_count_ff(pc), .wr_reject_ff(rj),
    .wr_enable_ff(we), .in_reset_ff(ir));
  ssr_mcu mcu (.rst_line_oe(loe), .force_low(fl), .rst_line(line));
  initial forever #20 mclk = ~mclk;
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task test_done;
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // bounded wait for release, the span must sit near the timeout
  task rel;
    n = 0;
    while (ir !== 1'b0 && n < 200)
    begin
      tick(1);
      n++;
    end
    if (n == 200) num_errors++;
    if (n == 200) test_done;
    chk("span", 8'(n >= TO && n <= TO + 12), 8'h01);
  endtask
  task wr(input int k, input logic ok);
    st = 1;
    a = 8'($urandom);
    tick(1);
    st = 0;
    repeat (k)
    begin
      bv = 1;
      b = 8'($urandom);
      tick(1);
    end
    bv = 0;
    cm = 1;
    tick(1);
    cm = 0;
    // accept and reject pulses stand for one cycle only
    chk("acc", {7'h00, pv}, {7'h00, ok});
    chk("rej", {7'h00, rj}, {7'h00, !ok});
    chk("wen", {7'h00, we}, {7'h00, ok});
    if (ok) chk("cnt", {3'h0, pc}, 8'(k > 16 ? 16 : k));
    if (ok) chk("addr", pa, a);
  endtask
  initial
  begin
    n = $urandom(32'h264B3ED6);
    tick(20);
    rst = 0;
    tick(2);
    chk("pwr", {6'h00, ir, hoe}, 8'h03);
    wr(2, 0);
    sl = 0;
    rel;
    wr(16, 1);
    wr(17, 1);
    repeat (4) wr(1 + $urandom % 20, 1);
    wp = 1;
    wr(4, 0);
    wp = 0;
    push = 0;
    tick(3);
    push = 1;
    tick(8);
    chk("glitch", {7'h00, ir}, 8'h00);
    push = 0;
    tick(12);
    chk("push", {7'h00, ir}, 8'h01);
    push = 1;
    rel;
    fl = 1;
    tick(4);
    chk("line", {7'h00, ir}, 8'h01);
    fl = 0;
    rel;
    sl = 1;
    tick(2);
    sl = 0;
    tick(TO / 2);
    sl = 1;
    tick(2);
    sl = 0;
    rel;
    test_done;
  end
endmodule
